// file: hw/rww_supervisor.v
// Operation
// - reset from three sources combined
// - internal undervoltage clears fail flag and settings
// - filtered regulator undervoltage drives reset, delayed release
// - release delay long by default, bit shortens
// - any reset forces standby, all outputs off
// - long open window after reset release
// - period field write is a trigger
// - trigger taken at chip select rise
// - correct trigger opens closed half period
// - open half period follows closed window
// - service in open window restarts closed window
// - trigger in closed window causes reset
// - failure flag set, cleared by SPI access
// - failure forces standby mode
// - low power keeps watchdog when requested
// - stop mode disables watchdog only below current
`timescale 1ns/1ps
`include "rww_consts.vh"

module rww_supervisor #(
  parameter FILTER_CYC = `RWW_FILTER_CYC,
  parameter DELAY_LONG_CYC = `RWW_DELAY_LONG_CYC,
  parameter DELAY_SHORT_CYC = `RWW_DELAY_SHORT_CYC,
  parameter LOW_CYC = `RWW_LOW_CYC,
  parameter HALF_UNIT_CYC = `RWW_HALF_UNIT_CYC,
  parameter PERIOD_W = `RWW_PERIOD_W
) (
  // clock and reset
  input wire sys_clk,
  input wire nrst,
  // analog comparators, asynchronous
  input wire internal_supply_undervoltage,
  input wire regulator_output_undervoltage,
  input wire wd_current_below_threshold,
  // decoded spi word, same clock domain
  input wire spi_access,
  input wire spi_cs_rise,
  input wire spi_period_write,
  input wire [PERIOD_W-1:0] spi_period,
  input wire spi_short_delay_write,
  input wire spi_short_delay,
  input wire spi_wd_lowpower_write,
  input wire spi_wd_lowpower,
  // requested operating mode, same clock domain
  input wire stop_low_power_mode,
  input wire low_power_mode,
  // outputs to pins and mode logic
  output reg reset_n,
  output reg standby_operating_mode,
  output reg low_side_switch_off,
  output reg supply_output_off,
  output reg led_high_side_output_off,
  // spi status
  output reg internal_supply_fail_flag,
  output reg wd_reset_flag,
  output reg wd_running,
  output reg [PERIOD_W-1:0] wd_period,
  output reg short_delay,
  output reg wd_lowpower_enable,
  output reg [1:0] wd_state
);

  // ****************************************
  // states and widths
  // ****************************************
  // counter wide enough for the longest delay or window at the default rate
  localparam CW = 24;
  // hold covers both the reset itself and the release delay
  localparam [1:0] ST_HOLD = 2'h0;
  localparam [1:0] ST_LONG = 2'h1;
  localparam [1:0] ST_CLOSED = 2'h2;
  localparam [1:0] ST_OPEN = 2'h3;

  // half window length in cycles for a period code
  function [CW-1:0] half_len;
    input [PERIOD_W-1:0] code;
    begin
      half_len = (({{(CW-PERIOD_W){1'b0}}, code}) + {{(CW-1){1'b0}}, 1'b1}) *
        HALF_UNIT_CYC[CW-1:0];
    end
  endfunction

  // true on the last cycle of a span of len cycles counted from zero;
  // shared by the delay and all three windows so their end points agree
  function reached;
    input [CW-1:0] count;
    input [CW-1:0] len;
    begin
      reached = (count + {{(CW-1){1'b0}}, 1'b1}) >= len;
    end
  endfunction

  // ****************************************
  // input synchronisers
  // ****************************************
  localparam NS = 3;
  // undervoltage stages start asserted so the release delay runs only once
  // the comparators have really been seen low after power-up
  localparam [NS-1:0] SYNC_RST = 3'h3;
  wire [NS-1:0] async_in = {wd_current_below_threshold, regulator_output_undervoltage,
    internal_supply_undervoltage};
  wire [NS-1:0] synced;
  wire iuv = synced[0];
  wire ruv = synced[1];
  wire cur_low = synced[2];

  // two flops per comparator, first stage read only by the second
  genvar gi;
  generate
    for (gi = 0; gi < NS; gi = gi + 1) begin : g_sync
      reg meta;
      reg stage;
      always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
          meta <= SYNC_RST[gi];
          stage <= SYNC_RST[gi];
        end else begin
          meta <= async_in[gi];
          stage <= meta;
        end
      end
      assign synced[gi] = stage;
    end
  endgenerate

  // ****************************************
  // regulator undervoltage filter
  // ****************************************
  reg [CW-1:0] filt_cnt;
  reg ruv_filtered;

  // brief dips shorter than the filter time are ignored; the filtered level
  // starts high so the delay never begins before the first clean samples, and
  // a single low sample clears it at once because release must not wait
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      filt_cnt <= {CW{1'b0}};
      ruv_filtered <= 1'b1;
    end else if (!ruv) begin
      filt_cnt <= {CW{1'b0}};
      ruv_filtered <= 1'b0;
    end else if (filt_cnt >= FILTER_CYC[CW-1:0]) begin
      ruv_filtered <= 1'b1;
    end else begin
      filt_cnt <= filt_cnt + {{(CW-1){1'b0}}, 1'b1};
    end
  end

  // ****************************************
  // configuration bits
  // ****************************************
  // settings are wiped by internal undervoltage only
  // a watchdog or regulator reset leaves them alone, so the controller need
  // not rewrite its period after every restart
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wd_period <= `RWW_PERIOD_RST;
      short_delay <= 1'b0;
      wd_lowpower_enable <= 1'b0;
    end else if (iuv) begin
      wd_period <= `RWW_PERIOD_RST;
      short_delay <= 1'b0;
      wd_lowpower_enable <= 1'b0;
    end else begin
      if (spi_period_write)
        wd_period <= spi_period;
      if (spi_short_delay_write)
        short_delay <= spi_short_delay;
      if (spi_wd_lowpower_write)
        wd_lowpower_enable <= spi_wd_lowpower;
    end
  end

  // ****************************************
  // internal supply fail bit
  // ****************************************
  // cleared by internal undervoltage and kept low until the controller has
  // made an spi access, so a supply loss is still visible after the controller
  // restarts; undervoltage wins over a simultaneous access
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      internal_supply_fail_flag <= 1'b0;
    end else if (iuv) begin
      internal_supply_fail_flag <= 1'b0;
    end else if (spi_access) begin
      internal_supply_fail_flag <= 1'b1;
    end
  end

  // ****************************************
  // watchdog enable in low power
  // ****************************************
  // stop mode may gate the watchdog only on low current; sleep mode gates it
  // unless the controller asked to keep it, and a gated watchdog restarts
  // its current window from zero when the gate opens again
  wire wd_gated = low_power_mode & ~wd_lowpower_enable &
    (~stop_low_power_mode | cur_low);

  // trigger is the period write, taken at the chip select rise; a word that
  // is cut short never raises the strobe and so never counts as a service
  wire trigger = spi_period_write & spi_cs_rise;

  // ****************************************
  // reset release and watchdog windows
  // ****************************************
  reg [CW-1:0] cnt;
  reg wd_fail;
  // wd_fail is a one-cycle pulse; it keeps reset_src high for the cycle in
  // which the flag is loaded, so standby never misses a failure
  wire reset_src = iuv | ruv_filtered | wd_fail;
  // the delay follows the short bit live, so a write during the delay counts
  wire [CW-1:0] delay_len = short_delay ? DELAY_SHORT_CYC[CW-1:0] :
    DELAY_LONG_CYC[CW-1:0];
  wire [CW-1:0] one = {{(CW-1){1'b0}}, 1'b1};

  // one counter serves the release delay and every window
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wd_state <= ST_HOLD;
      cnt <= {CW{1'b0}};
      reset_n <= 1'b0;
      wd_fail <= 1'b0;
    end else begin
      wd_fail <= 1'b0;
      case (wd_state)
        // reset low; the delay restarts whenever a source comes back
        ST_HOLD: begin
          reset_n <= 1'b0;
          if (iuv | ruv_filtered) begin
            cnt <= {CW{1'b0}};
          end else if (reached(cnt, delay_len)) begin
            reset_n <= 1'b1;
            cnt <= {CW{1'b0}};
            wd_state <= ST_LONG;
          end else begin
            cnt <= cnt + one;
          end
        end
        // long open window: any trigger is welcome, silence is a failure
        ST_LONG: begin
          if (reset_src) begin
            wd_state <= ST_HOLD;
            reset_n <= 1'b0;
            cnt <= {CW{1'b0}};
          end else if (trigger) begin
            wd_state <= ST_CLOSED;
            cnt <= {CW{1'b0}};
          end else if (wd_gated) begin
            cnt <= {CW{1'b0}};
          end else if (reached(cnt, LOW_CYC[CW-1:0])) begin
            wd_fail <= 1'b1;
            reset_n <= 1'b0;
            wd_state <= ST_HOLD;
            cnt <= {CW{1'b0}};
          end else begin
            cnt <= cnt + one;
          end
        end
        // closed window: a trigger here is too early
        ST_CLOSED: begin
          if (reset_src) begin
            wd_state <= ST_HOLD;
            reset_n <= 1'b0;
            cnt <= {CW{1'b0}};
          end else if (trigger & ~wd_gated) begin
            wd_fail <= 1'b1;
            reset_n <= 1'b0;
            wd_state <= ST_HOLD;
            cnt <= {CW{1'b0}};
          end else if (wd_gated) begin
            cnt <= {CW{1'b0}};
          end else if (reached(cnt, half_len(wd_period))) begin
            wd_state <= ST_OPEN;
            cnt <= {CW{1'b0}};
          end else begin
            cnt <= cnt + one;
          end
        end
        // open window: a trigger starts the next closed window
        ST_OPEN: begin
          if (reset_src) begin
            wd_state <= ST_HOLD;
            reset_n <= 1'b0;
            cnt <= {CW{1'b0}};
          end else if (trigger) begin
            wd_state <= ST_CLOSED;
            cnt <= {CW{1'b0}};
          end else if (wd_gated) begin
            cnt <= {CW{1'b0}};
          end else if (reached(cnt, half_len(wd_period))) begin
            wd_fail <= 1'b1;
            reset_n <= 1'b0;
            wd_state <= ST_HOLD;
            cnt <= {CW{1'b0}};
          end else begin
            cnt <= cnt + one;
          end
        end
        default: begin
          wd_state <= ST_HOLD;
          cnt <= {CW{1'b0}};
          reset_n <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************
  // status flag and forced standby
  // ****************************************
  // set wins over the spi clear so no failure is lost
  // internal undervoltage wipes it together with the other settings
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wd_reset_flag <= 1'b0;
    end else if (wd_fail) begin
      wd_reset_flag <= 1'b1;
    end else if (spi_access | iuv) begin
      wd_reset_flag <= 1'b0;
    end
  end

  // the release delay keeps everything off as well, so no load comes on
  // before the controller has left reset
  wire force_off = reset_src | (wd_state == ST_HOLD);

  // outputs held off while any reset source or the delay is active
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      standby_operating_mode <= 1'b1;
      low_side_switch_off <= 1'b1;
      supply_output_off <= 1'b1;
      led_high_side_output_off <= 1'b1;
      wd_running <= 1'b0;
    end else begin
      standby_operating_mode <= force_off | wd_fail;
      low_side_switch_off <= force_off;
      supply_output_off <= force_off;
      led_high_side_output_off <= force_off;
      // running means counting; a gated watchdog reads as stopped
      wd_running <= (wd_state != ST_HOLD) & ~wd_gated;
    end
  end

endmodule // rww_supervisor

// file: include/rww_consts.vh
`ifndef RWW_CONSTS_VH
`define RWW_CONSTS_VH
// ****************************************
// timing of the reset supervisor
// ****************************************
// oscillator rate in kHz, reset filter time and release delays in us
`define RWW_CLK_KHZ 200000
`define RWW_FILTER_US 10
`define RWW_FILTER_CYC ((`RWW_FILTER_US * `RWW_CLK_KHZ) / 1000)
`define RWW_DELAY_LONG_US 200
`define RWW_DELAY_LONG_CYC ((`RWW_DELAY_LONG_US * `RWW_CLK_KHZ) / 1000)
`define RWW_DELAY_SHORT_US 10
`define RWW_DELAY_SHORT_CYC ((`RWW_DELAY_SHORT_US * `RWW_CLK_KHZ) / 1000)
// ****************************************
// watchdog timing
// ****************************************
// long open window in us
`define RWW_LOW_US 200
`define RWW_LOW_CYC ((`RWW_LOW_US * `RWW_CLK_KHZ) / 1000)
// half period unit: half period = (code + 1) * unit cycles
`define RWW_HALF_UNIT_CYC 1000
`define RWW_PERIOD_W 4
// ****************************************
// configuration reset values
// ****************************************
`define RWW_PERIOD_RST 4'h0
`endif

// file: testbench/rww_mcu.sv
`timescale 1ns/1ps
// microcontroller side, one spi word per call
module rww_mcu (
  // clock and spi word strobes
  input wire sys_clk,
  output reg spi_access,
  output reg spi_cs_rise,
  output reg spi_period_write,
  output reg [3:0] spi_period,
  output reg spi_short_delay_write,
  output reg spi_short_delay
);
  // idle at time zero
  initial begin
    {spi_access, spi_cs_rise, spi_period_write, spi_short_delay_write} = 4'h0;
    spi_period = 4'h0;
    spi_short_delay = 1'b0;
  end
  // one-cycle strobes; stale field shows inverted so no old value leaks
  task write_word(input [3:0] code, input pw, input sd);
    begin
      @(posedge sys_clk);
      spi_access <= 1'b1;
      spi_cs_rise <= 1'b1;
      spi_period_write <= pw;
      spi_period <= code;
      spi_short_delay_write <= sd;
      spi_short_delay <= sd;
      @(posedge sys_clk);
      {spi_access, spi_cs_rise, spi_period_write, spi_short_delay_write} <= 4'h0;
      spi_period <= ~code;
    end
  endtask
endmodule // rww_mcu

// file: testbench/rww_supervisor_asserts.sv
`timescale 1ns/1ps
// ****************************************
// port checker
// ****************************************
module rww_supervisor_asserts #(
  parameter FILTER_CYC = 4,
  parameter HALF_UNIT_CYC = 4,
  parameter PERIOD_W = 4
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic internal_supply_undervoltage,
  input wire logic regulator_output_undervoltage,
  input wire logic spi_cs_rise,
  input wire logic spi_period_write,
  input wire logic reset_n,
  input wire logic standby_operating_mode,
  input wire logic low_side_switch_off,
  input wire logic supply_output_off,
  input wire logic led_high_side_output_off,
  input wire logic internal_supply_fail_flag,
  input wire logic wd_reset_flag,
  input wire logic [PERIOD_W-1:0] wd_period,
  input wire logic short_delay,
  input wire logic [1:0] wd_state
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  logic [15:0] uv_cnt;
  logic [15:0] cl_cnt;
  wire trig = spi_cs_rise && spi_period_write;
  // run lengths, so long filters need no huge repetition
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      uv_cnt <= 16'h0;
      cl_cnt <= 16'h0;
    end else begin
      uv_cnt <= regulator_output_undervoltage ? uv_cnt + 16'h1 : 16'h0;
      cl_cnt <= (wd_state == 2'h2) ? cl_cnt + 16'h1 : 16'h0;
    end
  end
  property p_open_trig; trig && wd_state == 2'h3 |=> wd_state == 2'h2; endproperty
  a_open_trig: assert property (p_open_trig) else $error("open trigger ignored");
  property p_early; trig && wd_state == 2'h2 |=> !reset_n; endproperty
  a_early: assert property (p_early) else $error("early trigger kept reset high");
  property p_flag; trig && wd_state == 2'h2 |-> ##2 wd_reset_flag; endproperty
  a_flag: assert property (p_flag) else $error("failure flag not set");
  property p_off;
    !reset_n |-> ##[1:2] (standby_operating_mode && low_side_switch_off &&
      supply_output_off && led_high_side_output_off);
  endproperty
  a_off: assert property (p_off) else $error("outputs on during reset");
  property p_int_uv;
    internal_supply_undervoltage [*4] |=> !internal_supply_fail_flag && !short_delay;
  endproperty
  a_int_uv: assert property (p_int_uv) else $error("settings kept on supply loss");
  property p_reg_uv; uv_cnt > FILTER_CYC + 3 |-> !reset_n; endproperty
  a_reg_uv: assert property (p_reg_uv) else $error("reset high during undervoltage");
  property p_closed; wd_state == 2'h2 |-> cl_cnt < (wd_period + 1) * HALF_UNIT_CYC; endproperty
  a_closed: assert property (p_closed) else $error("closed window too long");
  property p_next;
    wd_state == 2'h2 ##1 wd_state != 2'h2 |-> wd_state == 2'h3 || !reset_n;
  endproperty
  a_next: assert property (p_next) else $error("closed not followed by open");
  c_service: cover property (trig && wd_state == 2'h3);
  c_fail: cover property (trig && wd_state == 2'h2);
  c_uv: cover property (uv_cnt > FILTER_CYC + 3);
endmodule // rww_supervisor_asserts

bind rww_supervisor rww_supervisor_asserts #(.FILTER_CYC(FILTER_CYC),
  .HALF_UNIT_CYC(HALF_UNIT_CYC), .PERIOD_W(PERIOD_W)) u_chk (.*);

// file: testbench/rww_supervisor_tb.sv
`timescale 1ns/1ps
module rww_supervisor_tb;
  reg sys_clk;
  reg nrst = 1'b0;
  reg int_uv = 1'b0;
  reg reg_uv = 1'b0;
  reg cur_lo = 1'b0;
  reg stop_m = 1'b0;
  reg lp_m = 1'b0;
  reg lpw = 1'b0;
  reg lpv = 1'b0;
  wire wd_run, wd_lpe;
  integer miscompares = 0;
  integer n_tests = 0;
  integer n;
  wire acc, csr, pw, sdw, sd, reset_n, stby, lso, supo, ledo, isf, wdf, sdl;
  wire [3:0] per;
  wire [3:0] wd_period;
  wire [1:0] wd_state;
  rww_mcu u_mcu (.sys_clk(sys_clk), .spi_access(acc), .spi_cs_rise(csr),
    .spi_period_write(pw), .spi_period(per), .spi_short_delay_write(sdw),
    .spi_short_delay(sd));
  // small counts keep the run short
  rww_supervisor #(.FILTER_CYC(4), .DELAY_LONG_CYC(20), .DELAY_SHORT_CYC(5),
    .LOW_CYC(50), .HALF_UNIT_CYC(4)) u_dut (.sys_clk(sys_clk), .nrst(nrst),
    .internal_supply_undervoltage(int_uv), .regulator_output_undervoltage(reg_uv),
    .wd_current_below_threshold(cur_lo), .spi_access(acc), .spi_cs_rise(csr),
    .spi_period_write(pw), .spi_period(per), .spi_short_delay_write(sdw),
    .spi_short_delay(sd), .spi_wd_lowpower_write(lpw), .spi_wd_lowpower(lpv),
    .stop_low_power_mode(stop_m), .low_power_mode(lp_m), .reset_n(reset_n),
    .standby_operating_mode(stby), .low_side_switch_off(lso),
    .supply_output_off(supo), .led_high_side_output_off(ledo),
    .internal_supply_fail_flag(isf), .wd_reset_flag(wdf), .wd_running(wd_run),
    .wd_period(wd_period), .short_delay(sdl), .wd_lowpower_enable(wd_lpe),
    .wd_state(wd_state));
  // 200 MHz
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  task chk(input [15:0] got, input [15:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task final_report;
    begin
      $display("tests %0d miscompares %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  // outputs sampled on falling edges, away from the launching edge
  task count_while(input [1:0] st, input rst_lvl);
    begin
      n = 0;
      while (wd_state === st && reset_n === rst_lvl && n < 300) begin
        @(negedge sys_clk);
        n = n + 1;
      end
    end
  endtask
  task wait_rise;
    begin
      count_while(2'h0, 1'b0);
      chk(wd_state, 2'h1);
    end
  endtask
  task t_service;
    begin
      u_mcu.write_word(4'h1, 1'b1, 1'b0);
      @(negedge sys_clk);
      count_while(2'h2, 1'b1);
      chk(n, 16'h8);
      chk(wd_state, 2'h3);
      u_mcu.write_word(4'h1, 1'b1, 1'b0);
      @(negedge sys_clk);
      chk(wd_state, 2'h2);
      u_mcu.write_word(4'h1, 1'b1, 1'b0);
      repeat (2) @(negedge sys_clk);
      chk({reset_n, wdf, stby}, 3'h3);
      u_mcu.write_word(4'h1, 1'b0, 1'b0);
      @(negedge sys_clk);
      chk(wdf, 1'b0);
      wait_rise;
    end
  endtask
  task t_expire;
    begin
      count_while(2'h1, 1'b1);
      chk(n >= 49 && n <= 52, 1'b1);
      wait_rise;
    end
  endtask
  task t_short;
    begin
      u_mcu.write_word(4'h0, 1'b0, 1'b1);
      reg_uv <= 1'b1;
      repeat (12) @(negedge sys_clk);
      chk({reset_n, stby, lso, supo, ledo}, 5'hf);
      @(posedge sys_clk);
      reg_uv <= 1'b0;
      count_while(2'h0, 1'b0);
      chk(n >= 5 && n < 20, 1'b1);
    end
  endtask
  task t_int_uv;
    begin
      @(posedge sys_clk);
      int_uv <= 1'b1;
      repeat (6) @(negedge sys_clk);
      chk({reset_n, isf, sdl}, 3'h0);
      @(posedge sys_clk);
      int_uv <= 1'b0;
      wait_rise;
      chk(n >= 20 && n < 30, 1'b1);
      chk(isf, 1'b0);
      u_mcu.write_word(4'h0, 1'b0, 1'b0);
      @(negedge sys_clk);
      chk(isf, 1'b1);
    end
  endtask
  // stop mode with low then high current, then the keep-running request
  task t_lowpower;
    begin
      @(posedge sys_clk);
      lp_m <= 1'b1;
      stop_m <= 1'b1;
      cur_lo <= 1'b1;
      repeat (60) @(negedge sys_clk);
      chk({reset_n, wd_state, wd_run}, 4'ha);
      @(posedge sys_clk);
      cur_lo <= 1'b0;
      repeat (5) @(negedge sys_clk);
      chk(wd_run, 1'b1);
      @(posedge sys_clk);
      cur_lo <= 1'b1;
      lpw <= 1'b1;
      lpv <= 1'b1;
      @(posedge sys_clk);
      lpw <= 1'b0;
      repeat (5) @(negedge sys_clk);
      chk({wd_lpe, wd_run}, 2'h3);
      count_while(2'h1, 1'b1);
      chk(n >= 30 && n <= 50, 1'b1);
      @(negedge sys_clk);
      chk({reset_n, wdf}, 2'h1);
      @(posedge sys_clk);
      lp_m <= 1'b0;
      stop_m <= 1'b0;
      cur_lo <= 1'b0;
      wait_rise;
    end
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (20) @(posedge sys_clk);
    nrst <= 1'b1;
    @(negedge sys_clk);
    wait_rise;
    chk(wd_period, 4'h0);
    t_service;
    t_expire;
    t_short;
    t_int_uv;
    t_lowpower;
    final_report;
  end
  // hang guard, far beyond the few hundred cycles the tests need
  initial begin
    #50000;
    miscompares = miscompares + 1;
    final_report;
  end
endmodule // rww_supervisor_tb
